/* File: ccsr_deglitch.sv */
// Purpose: Level filter; output follows input after it held HOLD_TICKS.
// Assumes: i_tick is a one-cycle enable pulse.
// Notes:   i_clear forces the output low and restarts the filter.
`timescale 1ns/1ns
module ccsr_deglitch #(
    parameter int HOLD_TICKS = 160
) (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_tick,
    input  wire logic i_raw,
    input  wire logic i_clear,
    output logic      o_level
);
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic        level_q;
    logic        level_d;

    always_comb begin
        count_d = count_q;
        level_d = level_q;
        if (i_clear) begin
            count_d = 16'h0;
            level_d = 1'b0;
        end else if (i_raw == level_q) begin
            count_d = 16'h0;
        end else if (i_tick) begin
            if (count_q >= 16'(HOLD_TICKS - 1)) begin
                count_d = 16'h0;
                level_d = i_raw;
            end else begin
                count_d = count_q + 16'h1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            count_q <= 16'h0;
            level_q <= 1'b0;
        end else begin
            count_q <= count_d;
            level_q <= level_d;
        end
    end

    assign o_level = level_q;
endmodule

/* File: ccsr_host.sv */
// Purpose: Host model that reads and writes the charger registers.
// Assumes: Requests change on the falling edge of i_clock.
// Notes:   Released write data is inverted so stale values never match.
`timescale 1ns/1ns
module ccsr_host (
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    output logic      [7:0] o_addr,
    output logic            o_write,
    output logic      [7:0] o_wdata
);
    initial begin
        {o_addr, o_write, o_wdata} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock);
        o_addr  = a;
        o_write = 1'b1;
        o_wdata = d;
        @(negedge i_clock);
        o_write = 1'b0;
        o_wdata = ~d;
    endtask
    // Three idle cycles let status snapshots settle before the address.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        repeat (3) @(negedge i_clock);
        o_addr = a;
        @(negedge i_clock);
        d = i_rdata;
    endtask
endmodule

/* File: ccsr_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 100 MHz system clock; slow timers run from a 100 us tick.
// Notes:   Definitions only.
`ifndef CCSR_MAP_SVH
`define CCSR_MAP_SVH

`define CCSR_OFS_MAIN_CONFIG_TWO     8'h01
`define CCSR_OFS_GENERAL_STATE       8'h02
`define CCSR_OFS_CHARGE_STATE        8'h03
`define CCSR_CONFIG_RESET            8'h34

`define CCSR_BIT_THERMISTOR_OFF      7
`define CCSR_BIT_OVERCURRENT_OFF     6
`define CCSR_BIT_BATTERY_OV_OFF      5
`define CCSR_BIT_SWITCH_LIMIT        4
`define CCSR_BIT_RESTART_WAIT        3
`define CCSR_BIT_LDO_ENABLE          2
`define CCSR_BIT_WATCHDOG_HI         1
`define CCSR_BIT_WATCHDOG_LO         0

`define CCSR_CLOCK_NS                10
`define CCSR_TICK_NS                 100000
`define CCSR_TICK_CYCLES             (`CCSR_TICK_NS / `CCSR_CLOCK_NS)
`define CCSR_DEGLITCH_US             16000
`define CCSR_DEGLITCH_TICKS          ((`CCSR_DEGLITCH_US * 1000) / `CCSR_TICK_NS)
`define CCSR_RESTART_LONG_US         40000
`define CCSR_RESTART_SHORT_US        100
`define CCSR_RESTART_LONG_TICKS      ((`CCSR_RESTART_LONG_US * 1000 + `CCSR_TICK_NS - 1) / `CCSR_TICK_NS)
`define CCSR_RESTART_SHORT_TICKS     ((`CCSR_RESTART_SHORT_US * 1000 + `CCSR_TICK_NS - 1) / `CCSR_TICK_NS)
`define CCSR_WDOG_SHORT_S            80
`define CCSR_WDOG_MID_S              160
`define CCSR_WDOG_LONG_S             320
`define CCSR_TICKS_PER_S             (1000000000 / `CCSR_TICK_NS)
`define CCSR_OCP_CYCLES              8

`endif

/* File: ccsr_pkg.sv */
// Purpose: Types shared by the charger control and status registers.
// Assumes: Field layout as in ccsr_map.svh.
// Notes:   Struct field order matches the register bit order.
package ccsr_pkg;

    typedef enum logic [1:0] {
        CCSR_MODE_IDLE,
        CCSR_MODE_CHARGE,
        CCSR_MODE_REVERSE
    } ccsr_mode_e;

    typedef struct packed {
        logic       thermistor_profile_off;
        logic       overcurrent_latchoff_off;
        logic       battery_overvoltage_latch_off;
        logic       switch_current_limit_select;
        logic       input_overvoltage_restart_wait;
        logic       ldo_enable;
        logic [1:0] watchdog_period;
    } ccsr_config_s;

    typedef struct packed {
        logic       battery_low_flag;
        logic       irq_drive_flag;
        logic       reverse_request_pin_level;
        logic       input_undervoltage_flag;
        logic       input_overvoltage_flag;
        logic       gpio_input_level;
        logic [1:0] system_state;
    } ccsr_general_s;

    typedef struct packed {
        logic       charge_enable_pin_level;
        logic       thermal_active_flag;
        logic       input_current_limit_flag;
        logic       input_voltage_limit_flag;
        logic [3:0] charge_state_code;
    } ccsr_charge_s;

endpackage

/* File: ccsr_regs.sv */
// Purpose: Control register and status registers of a buck-boost charger.
// Assumes: Register port driven by the serial interface engine on i_clock.
// Notes:   Pin and comparator inputs are synchronous to i_clock.
`timescale 1ns/1ns
`include "ccsr_map.svh"

// Contract
// [R01] Thermistor-off bit disables thermistor output, profile, uses full settings.
// [R02] Latch-off enabled: shut converter after consecutive switch limit trips.
// [R03] Battery over-voltage latch-off disabled by default; charging auto-resumes.
// [R04] Limit select bit picks 8.5A (0) or 10A (1) for all switches.
// [R05] After input over-voltage clears, wait 40ms (0) or 100us (1).
// [R06] Watchdog field: 00 off, 01 80s, 10 160s, 11 320s.
// [R07] Watchdog counter cleared in idle mode and when disabled.
// [R08] Battery-low flag set below threshold in charge/reverse, zero in idle.
// [R09] Battery-low flag deglitched 16ms on both edges.
// [R10] IRQ flag shows our own pull-down drive, not pin level.
// [R11] Reverse request pin level shown live.
// [R12] Input under/over-voltage flags live in charge mode only.
// [R13] General-purpose input flag reads low on variants without the pin.
// [R14] System state: 00 idle, 01 charge, 10 reverse; 11 never.
// [R15] Charge-enable pin level shown as judged by its comparator.
// [R16] Thermal flag set while die thermal regulation is active; the code forces it to 0 in idle mode.
// [R17] Charger state code encodes charger machine; 1100-1111 invalid.
// [R18] Outside charge mode the charger state code reads 0000.
// [R19] Idle mode selected: no pin or override starts the converter.
// [R20] Writes to the status registers are ignored.
module ccsr_regs
    import ccsr_pkg::*;
#(
    parameter int TICK_CYCLES = `CCSR_TICK_CYCLES,
    parameter int OCP_CYCLES  = `CCSR_OCP_CYCLES,
    parameter bit HAS_GPIO    = 1'b0
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_write,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    input  wire logic       i_high_impedance_idle,
    input  wire logic       i_charge_override,
    input  wire logic       i_reverse_override,
    input  wire logic       i_charge_enable_pin,
    input  wire logic       i_reverse_request_pin_n,
    input  wire logic       i_battery_below_good,
    input  wire logic       i_irq_drive_low,
    input  wire logic       i_input_undervoltage,
    input  wire logic       i_input_overvoltage,
    input  wire logic       i_gpio_input,
    input  wire logic       i_thermal_regulation,
    input  wire logic       i_input_current_limit,
    input  wire logic       i_input_voltage_limit,
    input  wire logic [3:0] i_charger_machine_code,
    input  wire logic       i_switch_cycle,
    input  wire logic       i_switch_limit_trip,
    input  wire logic       i_battery_overvoltage,
    input  wire logic       i_watchdog_kick,
    output logic            o_charge_run,
    output logic            o_reverse_run,
    output logic            o_thermistor_drive_en,
    output logic            o_temperature_profile_en,
    output logic            o_switch_limit_high,
    output logic            o_ldo_enable,
    output logic            o_overcurrent_shutdown,
    output logic            o_battery_ov_latched,
    output logic            o_input_ov_wait,
    output logic            o_watchdog_expired
);
    localparam int WDOG_W = 22;

    ccsr_config_s  cfg_q,     cfg_d;
    ccsr_general_s gen_q,     gen_d;
    ccsr_charge_s  chg_q,     chg_d;
    ccsr_mode_e    mode_q,    mode_d;
    logic [7:0]    rdata_q,   rdata_d;
    logic [4:0]    ocp_cnt_q, ocp_cnt_d;
    logic          ocp_q,     ocp_d;
    logic          bov_q,     bov_d;
    logic [8:0]    wait_q,    wait_d;
    logic          ov_prev_q, ov_prev_d;
    logic [WDOG_W-1:0] wdog_q, wdog_d;
    logic          expired_q, expired_d;
    logic          tick;
    logic          battery_low;
    logic          charge_ok;
    logic          reverse_ok;

    // Watchdog limit in ticks; zero means the timer is off.
    function automatic logic [WDOG_W-1:0] wdog_limit(input logic [1:0] sel);
        case (sel)
            2'b01:   wdog_limit = WDOG_W'(`CCSR_WDOG_SHORT_S * `CCSR_TICKS_PER_S);
            2'b10:   wdog_limit = WDOG_W'(`CCSR_WDOG_MID_S * `CCSR_TICKS_PER_S);
            2'b11:   wdog_limit = WDOG_W'(`CCSR_WDOG_LONG_S * `CCSR_TICKS_PER_S);
            default: wdog_limit = '0;
        endcase
    endfunction

    ccsr_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .o_tick  (tick)
    );

    // The filter is held clear in idle so it restarts from good on exit.
    ccsr_deglitch #(
        .HOLD_TICKS (`CCSR_DEGLITCH_TICKS)
    ) u_battery_low (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_tick  (tick),
        .i_raw   (i_battery_below_good),
        .i_clear (mode_q == CCSR_MODE_IDLE), // [R08] [R09]
        .o_level (battery_low)
    );

    // Configuration register; only its own offset accepts writes.
    always_comb begin
        cfg_d = cfg_q;
        if (i_reg_write && i_reg_addr == `CCSR_OFS_MAIN_CONFIG_TWO) begin
            cfg_d = ccsr_config_s'(i_reg_wdata);
        end
    end

    // Converter run permission and the system state machine.
    always_comb begin
        charge_ok  = (i_charge_enable_pin || i_charge_override) && !ocp_q
                     && !bov_q && !(i_battery_overvoltage
                     && cfg_q.battery_overvoltage_latch_off)
                     && !i_input_overvoltage && wait_q == 9'h0; // [R03] [R05]
        reverse_ok = (!i_reverse_request_pin_n || i_reverse_override)
                     && !ocp_q;
        case (mode_q)
            CCSR_MODE_IDLE, CCSR_MODE_CHARGE, CCSR_MODE_REVERSE: begin
                if (i_high_impedance_idle) begin
                    mode_d = CCSR_MODE_IDLE; // [R19]
                end else if (charge_ok) begin
                    mode_d = CCSR_MODE_CHARGE;
                end else if (reverse_ok) begin
                    mode_d = CCSR_MODE_REVERSE;
                end else begin
                    mode_d = CCSR_MODE_IDLE;
                end
            end
            default: mode_d = CCSR_MODE_IDLE;
        endcase
    end

    // Protection: consecutive limit trips, battery over-voltage latch and
    // the restart wait after input over-voltage. Latches clear while i_high_impedance_idle is set.
    always_comb begin
        ocp_cnt_d = ocp_cnt_q;
        ocp_d     = ocp_q;
        bov_d     = bov_q;
        wait_d    = wait_q;
        ov_prev_d = i_input_overvoltage;
        if (i_switch_cycle && mode_q != CCSR_MODE_IDLE) begin
            if (!i_switch_limit_trip) begin
                ocp_cnt_d = 5'h0;
            end else if (ocp_cnt_q >= 5'(OCP_CYCLES - 1)) begin
                ocp_cnt_d = 5'h0;
                ocp_d     = !cfg_q.overcurrent_latchoff_off; // [R02]
            end else begin
                ocp_cnt_d = ocp_cnt_q + 5'h1;
            end
        end
        if (mode_q == CCSR_MODE_CHARGE && i_battery_overvoltage
            && !cfg_q.battery_overvoltage_latch_off) begin
            bov_d = 1'b1; // [R03]
        end
        if (ov_prev_q && !i_input_overvoltage) begin
            wait_d = cfg_q.input_overvoltage_restart_wait
                     ? 9'(`CCSR_RESTART_SHORT_TICKS)
                     : 9'(`CCSR_RESTART_LONG_TICKS); // [R05]
        end else if (tick && wait_q != 9'h0) begin
            wait_d = wait_q - 9'h1;
        end
        if (i_high_impedance_idle) begin
            ocp_d     = 1'b0;
            ocp_cnt_d = 5'h0;
            bov_d     = 1'b0;
        end
    end

    // Host watchdog; a kick or expiry restarts the count.
    always_comb begin
        wdog_d    = wdog_q;
        expired_d = expired_q;
        if (mode_q == CCSR_MODE_IDLE || cfg_q.watchdog_period == 2'b00) begin
            wdog_d    = '0; // [R07]
            expired_d = 1'b0;
        end else if (i_watchdog_kick) begin
            // An expiry landing in the same cycle as a kick still sets it.
            wdog_d    = '0;
            expired_d = tick && wdog_q
                        >= wdog_limit(cfg_q.watchdog_period) - WDOG_W'(1);
        end else if (tick) begin
            if (wdog_q >= wdog_limit(cfg_q.watchdog_period) - WDOG_W'(1)) begin
                wdog_d    = '0; // [R06]
                expired_d = 1'b1;
            end else begin
                wdog_d = wdog_q + WDOG_W'(1);
            end
        end
    end

    // Status snapshots; host writes never reach these.
    always_comb begin
        gen_d.battery_low_flag          = battery_low
                                          && mode_q != CCSR_MODE_IDLE; // [R08]
        gen_d.irq_drive_flag            = i_irq_drive_low; // [R10]
        gen_d.reverse_request_pin_level = i_reverse_request_pin_n; // [R11]
        gen_d.input_undervoltage_flag   = i_input_undervoltage
                                          && mode_q == CCSR_MODE_CHARGE; // [R12]
        gen_d.input_overvoltage_flag    = i_input_overvoltage
                                          && mode_q == CCSR_MODE_CHARGE; // [R12]
        gen_d.gpio_input_level          = HAS_GPIO && i_gpio_input; // [R13]
        gen_d.system_state              = mode_q; // [R14]
        chg_d.charge_enable_pin_level   = i_charge_enable_pin; // [R15]
        chg_d.thermal_active_flag       = i_thermal_regulation
                                          && mode_q != CCSR_MODE_IDLE; // [R16]
        chg_d.input_current_limit_flag  = i_input_current_limit
                                          && mode_q == CCSR_MODE_CHARGE;
        chg_d.input_voltage_limit_flag  = i_input_voltage_limit
                                          && mode_q == CCSR_MODE_CHARGE;
        if (mode_q == CCSR_MODE_CHARGE && i_charger_machine_code < 4'hc) begin
            chg_d.charge_state_code = i_charger_machine_code; // [R17]
        end else begin
            chg_d.charge_state_code = 4'h0; // [R18]
        end
        case (i_reg_addr)
            `CCSR_OFS_MAIN_CONFIG_TWO: rdata_d = cfg_q;
            `CCSR_OFS_GENERAL_STATE:   rdata_d = gen_q; // [R20]
            `CCSR_OFS_CHARGE_STATE:    rdata_d = chg_q; // [R20]
            default:                   rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            cfg_q     <= ccsr_config_s'(`CCSR_CONFIG_RESET);
            gen_q     <= '0;
            chg_q     <= '0;
            mode_q    <= CCSR_MODE_IDLE;
            rdata_q   <= 8'h00;
            ocp_cnt_q <= 5'h0;
            ocp_q     <= 1'b0;
            bov_q     <= 1'b0;
            wait_q    <= 9'h0;
            ov_prev_q <= 1'b0;
            wdog_q    <= '0;
            expired_q <= 1'b0;
        end else begin
            cfg_q     <= cfg_d;
            gen_q     <= gen_d;
            chg_q     <= chg_d;
            mode_q    <= mode_d;
            rdata_q   <= rdata_d;
            ocp_cnt_q <= ocp_cnt_d;
            ocp_q     <= ocp_d;
            bov_q     <= bov_d;
            wait_q    <= wait_d;
            ov_prev_q <= ov_prev_d;
            wdog_q    <= wdog_d;
            expired_q <= expired_d;
        end
    end

    // Full settings apply whenever the profile control is switched off.
    assign o_thermistor_drive_en    = !cfg_q.thermistor_profile_off; // [R01]
    assign o_temperature_profile_en = !cfg_q.thermistor_profile_off; // [R01]
    assign o_switch_limit_high      = cfg_q.switch_current_limit_select; // [R04]
    assign o_ldo_enable             = cfg_q.ldo_enable;
    assign o_charge_run             = mode_q == CCSR_MODE_CHARGE;
    assign o_reverse_run            = mode_q == CCSR_MODE_REVERSE;
    assign o_overcurrent_shutdown   = ocp_q;
    assign o_battery_ov_latched     = bov_q;
    assign o_input_ov_wait          = wait_q != 9'h0;
    assign o_watchdog_expired       = expired_q;
    assign o_reg_rdata              = rdata_q;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence s_last_trip;
        i_switch_cycle && i_switch_limit_trip && mode_q != CCSR_MODE_IDLE
        && ocp_cnt_q == 5'(OCP_CYCLES - 1) && !i_high_impedance_idle;
    endsequence

    sequence s_ov_cleared;
        ov_prev_q && !i_input_overvoltage;
    endsequence

    AST_THERM_OFF: assert property ( // [R01]
        cfg_q.thermistor_profile_off |-> !o_thermistor_drive_en
        && !o_temperature_profile_en)
        else $error("Thermistor path active while disabled.");
    AST_OCP_LATCH: assert property ( // [R02]
        s_last_trip ##0 !cfg_q.overcurrent_latchoff_off |=> o_overcurrent_shutdown
        ##1 !o_charge_run && !o_reverse_run)
        else $error("Converter kept running after limit trips.");
    AST_BOV_POLICY: assert property ( // [R03]
        $rose(o_battery_ov_latched) |-> $past(!cfg_q.battery_overvoltage_latch_off))
        else $error("Battery over-voltage latched while latch is off.");
    AST_LIMIT_SEL: assert property ( // [R04]
        i_reg_write && i_reg_addr == `CCSR_OFS_MAIN_CONFIG_TWO
        |=> o_switch_limit_high == $past(i_reg_wdata[`CCSR_BIT_SWITCH_LIMIT]))
        else $error("Switch limit select not applied.");
    AST_OV_WAIT: assert property ( // [R05]
        s_ov_cleared ##0 cfg_q.input_overvoltage_restart_wait
        |=> wait_q == 9'(`CCSR_RESTART_SHORT_TICKS))
        else $error("Restart wait not loaded after over-voltage cleared.");
    AST_WDOG_IDLE: assert property ( // [R07]
        mode_q == CCSR_MODE_IDLE |=> wdog_q == '0 && !o_watchdog_expired)
        else $error("Watchdog running in idle mode.");
    AST_BATLOW_IDLE: assert property ( // [R08]
        mode_q == CCSR_MODE_IDLE |=> !gen_q.battery_low_flag)
        else $error("Battery-low flag set in idle mode.");
    AST_STATE_VALID: assert property ( // [R14]
        gen_q.system_state != 2'b11)
        else $error("Invalid system state reported.");
    AST_CODE_RESET: assert property ( // [R18]
        mode_q != CCSR_MODE_CHARGE |=> chg_q.charge_state_code == 4'h0)
        else $error("Charger code not reset outside charge mode.");
    AST_IDLE_HOLD: assert property ( // [R19]
        i_high_impedance_idle |=> mode_q == CCSR_MODE_IDLE)
        else $error("Converter started while idle selected.");
    AST_RO_WRITE: assert property ( // [R20]
        i_reg_write && i_reg_addr != `CCSR_OFS_MAIN_CONFIG_TWO |=> $stable(cfg_q))
        else $error("Write to a status register changed the config.");
endmodule

/* File: ccsr_regs_bench.sv */
// Purpose: Self-checking bench for the charger control and status block.
// Assumes: 100 MHz clock; inputs change on the falling edge.
// Notes:   A two-cycle tick keeps the slow timers short.
`timescale 1ns/1ns
module ccsr_regs_bench;
    logic       clock = 1'b0;
    logic       rst_n, wr_en, idle, c_ovr, r_ovr, c_pin, r_pin_n;
    logic       bat_low, irq, uv, ov, gpio, therm, ilim, vlim, sw, trip;
    logic       bov, kick, c_run, r_run, th_en, pr_en, lim_hi, ldo;
    logic       ocp, bov_l, ov_wait, wd_exp;
    logic [7:0] addr, wdata, rdata, v;
    logic [3:0] code;
    int         fails = 0;
    int         n_compared = 0;
    int         cnt;
    always #5 clock = ~clock;
    ccsr_host i_host (.i_clock(clock), .i_rdata(rdata), .o_addr(addr),
        .o_write(wr_en), .o_wdata(wdata));
    ccsr_regs #(.TICK_CYCLES(2), .OCP_CYCLES(8), .HAS_GPIO(1'b0)) i_dut (
        .i_clock(clock), .i_rst_n(rst_n), .i_reg_addr(addr),
        .i_reg_write(wr_en), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_high_impedance_idle(idle), .i_charge_override(c_ovr),
        .i_reverse_override(r_ovr), .i_charge_enable_pin(c_pin),
        .i_reverse_request_pin_n(r_pin_n), .i_battery_below_good(bat_low),
        .i_irq_drive_low(irq), .i_input_undervoltage(uv),
        .i_input_overvoltage(ov), .i_gpio_input(gpio),
        .i_thermal_regulation(therm), .i_input_current_limit(ilim),
        .i_input_voltage_limit(vlim), .i_charger_machine_code(code),
        .i_switch_cycle(sw), .i_switch_limit_trip(trip),
        .i_battery_overvoltage(bov), .i_watchdog_kick(kick),
        .o_charge_run(c_run), .o_reverse_run(r_run),
        .o_thermistor_drive_en(th_en), .o_temperature_profile_en(pr_en),
        .o_switch_limit_high(lim_hi), .o_ldo_enable(ldo),
        .o_overcurrent_shutdown(ocp), .o_battery_ov_latched(bov_l),
        .o_input_ov_wait(ov_wait), .o_watchdog_expired(wd_exp));
    task automatic end_of_test();
        $display("Compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, v);
        check(v, exp);
    endtask
    task automatic trips(input int n, input logic t);
        repeat (n) begin
            @(negedge clock);
            {sw, trip} = {1'b1, t};
            @(negedge clock);
            {sw, trip} = 2'h0;
        end
    endtask
    // The wait is counted from the cycle after the fault clears.
    task automatic ov_pulse();
        ov = 1'b1;
        repeat (3) @(negedge clock);
        ov = 1'b0;
        @(negedge clock);
        check({7'h0, ov_wait}, 8'h01);
        cnt = 0;
        while (ov_wait === 1'b1 && cnt < 2000) begin
            @(negedge clock);
            cnt++;
        end
        if (cnt >= 2000) begin
            fails++;
            end_of_test();
        end
    endtask
    initial begin
        {rst_n, idle, c_ovr, r_ovr, c_pin, bat_low, irq, uv, ov} = '0;
        {gpio, therm, ilim, vlim, sw, trip, bov, kick, code} = '0;
        r_pin_n = 1'b1;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        rc(8'h01, 8'h34);
        check({4'h0, th_en, pr_en, lim_hi, ldo}, 8'h0f);
        i_host.wr(8'h01, 8'hc8);
        i_host.wr(8'h02, 8'hff);
        i_host.wr(8'h03, 8'hff);
        check({4'h0, th_en, pr_en, lim_hi, ldo}, 8'h00);
        rc(8'h01, 8'hc8);
        rc(8'h02, 8'h20);
        rc(8'h03, 8'h00);
        rc(8'h7f, 8'h00);
        i_host.wr(8'h01, 8'h34);
        {idle, c_ovr, r_ovr, c_pin, irq, gpio, r_pin_n} = 7'h7e;
        rc(8'h02, 8'h40);
        check({6'h0, c_run, r_run}, 8'h00);
        {idle, c_ovr, r_ovr, uv, therm, ilim, r_pin_n} = 7'h0f;
        code = 4'h5;
        rc(8'h02, 8'h71);
        rc(8'h03, 8'he5);
        code = 4'hc;
        rc(8'h03, 8'he0);
        {c_pin, r_pin_n, vlim} = 3'h1;
        // A valid code outside charge mode must still read as reset.
        code = 4'h5;
        rc(8'h02, 8'h42);
        rc(8'h03, 8'h40);
        trips(7, 1'b1);
        trips(1, 1'b0);
        trips(7, 1'b1);
        check({7'h0, ocp}, 8'h00);
        trips(1, 1'b1);
        repeat (2) @(negedge clock);
        check({6'h0, ocp, r_run}, 8'h02);
        idle = 1'b1;
        repeat (2) @(negedge clock);
        idle = 1'b0;
        check({7'h0, ocp}, 8'h00);
        i_host.wr(8'h01, 8'h74);
        trips(8, 1'b1);
        repeat (2) @(negedge clock);
        check({6'h0, ocp, r_run}, 8'h01);
        i_host.wr(8'h01, 8'h34);
        {c_pin, r_pin_n, bat_low, uv} = 4'he;
        repeat (250) @(negedge clock);
        rc(8'h02, 8'h61);
        repeat (100) @(negedge clock);
        rc(8'h02, 8'he1);
        bat_low = 1'b0;
        repeat (250) @(negedge clock);
        rc(8'h02, 8'he1);
        repeat (100) @(negedge clock);
        rc(8'h02, 8'h61);
        {idle, bat_low} = 2'h3;
        repeat (400) @(negedge clock);
        rc(8'h02, 8'h60);
        {idle, bat_low, bov} = 3'h1;
        repeat (3) @(negedge clock);
        check({6'h0, c_run, bov_l}, 8'h00);
        bov = 1'b0;
        repeat (3) @(negedge clock);
        check({6'h0, c_run, bov_l}, 8'h02);
        i_host.wr(8'h01, 8'h14);
        bov = 1'b1;
        repeat (3) @(negedge clock);
        bov = 1'b0;
        repeat (3) @(negedge clock);
        check({6'h0, c_run, bov_l}, 8'h01);
        i_host.wr(8'h01, 8'h35);
        kick = 1'b1;
        @(negedge clock);
        kick = 1'b0;
        repeat (20) @(negedge clock);
        check({7'h0, wd_exp}, 8'h00);
        ov_pulse();
        check({7'h0, cnt >= 790 && cnt <= 810}, 8'h01);
        i_host.wr(8'h01, 8'h3c);
        ov_pulse();
        check({7'h0, cnt <= 3}, 8'h01);
        end_of_test();
    end
endmodule

/* File: ccsr_tick.sv */
// Purpose: Divider giving a one-cycle enable pulse for the slow timers.
// Assumes: TICK_CYCLES of at least 1.
// Notes:   All slow timing in the block counts these pulses.
`timescale 1ns/1ns
module ccsr_tick #(
    parameter int TICK_CYCLES = 10000
) (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    output logic      o_tick
);
    logic [31:0] count_q;
    logic [31:0] count_d;

    always_comb begin
        if (count_q >= 32'(TICK_CYCLES - 1)) begin
            count_d = 32'h0;
        end else begin
            count_d = count_q + 32'h1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            count_q <= 32'h0;
        end else begin
            count_q <= count_d;
        end
    end

    assign o_tick = (count_q >= 32'(TICK_CYCLES - 1));
endmodule
